// [pkg/fifo_flags_regs.vh]
// Functional notes
// - Big order: first narrow byte lands low; wide word reads low half first.
// - Little order: first narrow byte lands high; wide word reads high half first.
// - Empty flag rises when the stored occupancy reaches zero.
// - Nearly-empty flag uses a programmable threshold from one to full minus one.
// - Full flag uses a programmable capacity threshold from one to maximum depth.
// - Nearly-full flag uses a programmable threshold from one to full minus one.
// - Each flag goes high when the occupancy counter reaches its threshold.
// - Thresholds are 14 bits, bit 13 zero, bits 12 to 3 count 9-bit half-words.
// - Threshold bits 2 to 0 never matter; bit 3 matters only when both ports are narrow.
// - Write port has a 3-bit chip select with selectable polarity.
// - Read port has a 3-bit chip select with selectable polarity.
// - The FIFO runs from one common clock, core_clk, shared by write and read.
// - Port widths follow the simple dual-port options, at most 18 bits.
`ifndef FIFO_FLAGS_REGS_VH
`define FIFO_FLAGS_REGS_VH

`define FF_DATA_W      18
`define FF_HALF_W      9
`define FF_DEPTH       11'h400
`define FF_PTR_W       10
`define FF_CNT_W       11
`define FF_THR_W       14
`define FF_CS_W        3
`define FF_THR_LSB     3
`define FF_THR_MSB     13
`define FF_EMPTY_THR   11'h000
`define FF_CNT_RST     11'h000
`define FF_PTR_RST     10'h000
`define FF_DATA_RST    18'h00000

`endif

// [hw/cs_match.v]
`include "fifo_flags_regs.vh"

// Decides whether a 3-bit chip select is active under its polarity mask.
module cs_match (
    input  wire [`FF_CS_W-1:0] sel,
    input  wire [`FF_CS_W-1:0] invert,
    output wire                active
);

    wire [`FF_CS_W-1:0] bit_ok;

    // Each select bit is active high unless its invert bit makes it active low.
    genvar i;
    generate
        for (i = 0; i < `FF_CS_W; i = i + 1) begin : g_bit
            assign bit_ok[i] = sel[i] ^ invert[i];
        end
    endgenerate

    // All three selects must agree, mirroring a decoded bank select.
    assign active = &bit_ok;

endmodule // cs_match

// [hw/fifo_store.v]
`include "fifo_flags_regs.vh"

// Half-word storage with two write and two read positions for wide accesses.
module fifo_store (
    input  wire                 core_clk,
    input  wire                 ce,
    input  wire                 we0,
    input  wire                 we1,
    input  wire [`FF_PTR_W-1:0]  waddr0,
    input  wire [`FF_PTR_W-1:0]  waddr1,
    input  wire [`FF_HALF_W-1:0] wdata0,
    input  wire [`FF_HALF_W-1:0] wdata1,
    input  wire [`FF_PTR_W-1:0]  raddr0,
    input  wire [`FF_PTR_W-1:0]  raddr1,
    output wire [`FF_HALF_W-1:0] rdata0,
    output wire [`FF_HALF_W-1:0] rdata1
);

    reg [`FF_HALF_W-1:0] mem [0:`FF_DEPTH-1];

    // Stored data has no reset; only the pointers define what is valid.
    always @(posedge core_clk) begin
        if (ce && we0) begin
            mem[waddr0] <= wdata0;
        end
        if (ce && we1) begin
            mem[waddr1] <= wdata1;
        end
    end

    // Reads are combinational; the caller registers the result.
    assign rdata0 = mem[raddr0];
    assign rdata1 = mem[raddr1];

endmodule // fifo_store

// [hw/embedded_fifo_flags.v]
`include "fifo_flags_regs.vh"

// Common-clock FIFO with width conversion, byte order and four level flags.
module embedded_fifo_flags (
    input  wire                 core_clk,
    input  wire                 rst,
    input  wire                 ce,
    input  wire                 wr_wide,
    input  wire                 rd_wide,
    input  wire                 big_endian,
    input  wire [`FF_THR_W-1:0]  nearly_empty_threshold,
    input  wire [`FF_THR_W-1:0]  nearly_full_threshold,
    input  wire [`FF_THR_W-1:0]  full_threshold,
    input  wire [`FF_CS_W-1:0]   wr_cs,
    input  wire [`FF_CS_W-1:0]   wr_cs_invert,
    input  wire [`FF_DATA_W-1:0] wr_data,
    input  wire [`FF_CS_W-1:0]   rd_cs,
    input  wire [`FF_CS_W-1:0]   rd_cs_invert,
    output reg  [`FF_DATA_W-1:0] rd_data,
    output reg                  rd_valid,
    output reg                  wr_done,
    output reg                  empty_out,
    output reg                  nearly_empty_out,
    output reg                  full_out,
    output reg                  nearly_full_out,
    output reg  [`FF_CNT_W-1:0]  level
);

    // Pointer and occupancy state, all in 9-bit half-word units.
    reg  [`FF_PTR_W-1:0]  wptr_r;
    reg  [`FF_PTR_W-1:0]  wptr_nxt;
    reg  [`FF_PTR_W-1:0]  rptr_r;
    reg  [`FF_PTR_W-1:0]  rptr_nxt;
    reg  [`FF_CNT_W-1:0]  count_r;
    reg  [`FF_CNT_W-1:0]  count_nxt;

    wire                 wr_sel;
    wire                 rd_sel;
    wire [`FF_CNT_W-1:0]  wr_need;
    wire [`FF_CNT_W-1:0]  rd_need;
    wire                 any_wide;
    wire [`FF_CNT_W-1:0]  ne_units;
    wire [`FF_CNT_W-1:0]  nf_units;
    wire [`FF_CNT_W-1:0]  full_units;
    wire [`FF_CNT_W-1:0]  cap_units;
    wire                 wr_ok;
    wire                 rd_ok;
    wire [`FF_PTR_W-1:0]  wptr_inc;
    wire [`FF_PTR_W-1:0]  rptr_inc;
    wire [`FF_HALF_W-1:0] wdata0;
    wire [`FF_HALF_W-1:0] wdata1;
    wire [`FF_HALF_W-1:0] rdata0;
    wire [`FF_HALF_W-1:0] rdata1;
    wire [`FF_DATA_W-1:0] rd_word;

    cs_match u_wr_cs (
        .sel    (wr_cs),
        .invert (wr_cs_invert),
        .active (wr_sel)
    );

    cs_match u_rd_cs (
        .sel    (rd_cs),
        .invert (rd_cs_invert),
        .active (rd_sel)
    );

    // port width choice
    // A wide port moves two halves per access, a narrow one moves a single half.
    assign wr_need = wr_wide ? 11'h002 : 11'h001;
    assign rd_need = rd_wide ? 11'h002 : 11'h001;
    assign any_wide = wr_wide | rd_wide;

    // threshold scaling
    // Bits 12 to 3 address half-words; bit 13 is forced out of the comparison.
    // width-dependent low bits
    // Bits 2 to 0 never count, and bit 3 is dropped once either port is wide,
    // so the flags only trip on whole accesses.
    assign ne_units = {1'b0, nearly_empty_threshold[`FF_THR_MSB-1:`FF_THR_LSB+1],
                       nearly_empty_threshold[`FF_THR_LSB] & ~any_wide};
    assign nf_units = {1'b0, nearly_full_threshold[`FF_THR_MSB-1:`FF_THR_LSB+1],
                       nearly_full_threshold[`FF_THR_LSB] & ~any_wide};
    assign full_units = {1'b0, full_threshold[`FF_THR_MSB-1:`FF_THR_LSB+1],
                         full_threshold[`FF_THR_LSB] & ~any_wide};

    // capacity limit
    // The usable capacity is the full threshold, clipped to the physical depth.
    // A zero threshold is out of range and is treated as the maximum depth.
    assign cap_units = ((full_units == 11'h000) || (full_units > `FF_DEPTH)) ? `FF_DEPTH : full_units;

    // gated access
    // A write needs room for every half it carries; a read needs that many
    // halves stored. A wide read against a single stored half is refused so
    // that no half-word is invented.
    // overflow guard
    // The same checks keep the pointers safe even if the user does not gate
    // the selects with the flags.
    assign wr_ok = wr_sel && ((count_r + wr_need) <= cap_units);
    assign rd_ok = rd_sel && (count_r >= rd_need);

    assign wptr_inc = wptr_r + 10'h001;
    assign rptr_inc = rptr_r + 10'h001;

    // byte order on write
    // The half stored first is the one handed back first by a narrow read.
    assign wdata0 = wr_wide ? (big_endian ? wr_data[`FF_HALF_W-1:0] : wr_data[`FF_DATA_W-1:`FF_HALF_W])
                            : wr_data[`FF_HALF_W-1:0];
    assign wdata1 = big_endian ? wr_data[`FF_DATA_W-1:`FF_HALF_W] : wr_data[`FF_HALF_W-1:0];

    fifo_store u_store (
        .core_clk (core_clk),
        .ce       (ce),
        .we0      (wr_ok),
        .we1      (wr_ok & wr_wide),
        .waddr0   (wptr_r),
        .waddr1   (wptr_inc),
        .wdata0   (wdata0),
        .wdata1   (wdata1),
        .raddr0   (rptr_r),
        .raddr1   (rptr_inc),
        .rdata0   (rdata0),
        .rdata1   (rdata1)
    );

    // byte order on read
    // On a wide read the oldest half goes low in big order and high in little order; a narrow read puts it low.
    assign rd_word = rd_wide ? (big_endian ? {rdata1, rdata0} : {rdata0, rdata1})
                             : {{`FF_HALF_W{1'b0}}, rdata0};

    // Next pointers and occupancy; writes and reads in one edge both count.
    always @* begin
        wptr_nxt  = wptr_r;
        rptr_nxt  = rptr_r;
        count_nxt = count_r;
        if (wr_ok) begin
            wptr_nxt = wptr_r + wr_need[`FF_PTR_W-1:0];
        end
        if (rd_ok) begin
            rptr_nxt = rptr_r + rd_need[`FF_PTR_W-1:0];
        end
        case ({wr_ok, rd_ok})
            2'b10: begin
                count_nxt = count_r + wr_need;
            end
            2'b01: begin
                count_nxt = count_r - rd_need;
            end
            2'b11: begin
                count_nxt = count_r + wr_need - rd_need;
            end
            default: begin
                count_nxt = count_r;
            end
        endcase
    end

    // frozen when idle
    // Pointer state moves only on enabled edges with an accepted access.
    // Reset also needs the clock enable, so a frozen block stays frozen.
    always @(posedge core_clk) begin
        if (ce && rst) begin
            wptr_r  <= `FF_PTR_RST;
            rptr_r  <= `FF_PTR_RST;
            count_r <= `FF_CNT_RST;
        end else if (ce) begin
            wptr_r  <= wptr_nxt;
            rptr_r  <= rptr_nxt;
            count_r <= count_nxt;
        end
    end

    // Read data and strobes are registered so every output leaves a flip-flop.
    // Read data holds its last value between reads rather than clearing.
    always @(posedge core_clk) begin
        if (ce && rst) begin
            rd_data  <= `FF_DATA_RST;
            rd_valid <= 1'b0;
            wr_done  <= 1'b0;
        end else if (ce) begin
            rd_valid <= rd_ok;
            wr_done  <= wr_ok;
            if (rd_ok) begin
                rd_data <= rd_word;
            end
        end
    end

    // flags track the counter
    // Flags are computed from the next occupancy so they change on the same
    // edge as the access that moves the counter, with no extra lag.
    always @(posedge core_clk) begin
        if (ce && rst) begin
            empty_out        <= 1'b1;
            nearly_empty_out <= 1'b1;
            full_out         <= 1'b0;
            nearly_full_out  <= 1'b0;
            level            <= `FF_CNT_RST;
        end else if (ce) begin
            empty_out        <= (count_nxt == `FF_EMPTY_THR);
            nearly_empty_out <= (count_nxt <= ne_units);
            full_out         <= (count_nxt >= cap_units);
            nearly_full_out  <= (nf_units != 11'h000) && (count_nxt >= nf_units);
            level            <= count_nxt;
        end
    end

    // clocking
    // Only the common-clock arrangement is built here; write and read share
    // core_clk, so every flag belongs to that single domain.

endmodule // embedded_fifo_flags

// [tb/fifo_user_model.sv]
// Producer and consumer selects; obey low lets the bench push past the flags.
module fifo_user_model (
    input  wire       wr_en,
    input  wire       rd_en,
    input  wire       obey,
    input  wire       full_out,
    input  wire       empty_out,
    input  wire [2:0] wr_cs_invert,
    input  wire [2:0] rd_cs_invert,
    output wire [2:0] wr_cs,
    output wire [2:0] rd_cs
);
    timeunit 1ns;
    timeprecision 1ps;
    // flag gated selects
    // Idle selects match only some bits, so a partial match must not count as active.
    assign wr_cs = (wr_en && !(obey && full_out)) ? ~wr_cs_invert : wr_cs_invert ^ 3'h3;
    assign rd_cs = (rd_en && !(obey && empty_out)) ? ~rd_cs_invert : rd_cs_invert ^ 3'h6;
endmodule // fifo_user_model

// [tb/embedded_fifo_flags_sva.sv]
// Port checker for the flag FIFO.
module fifo_flags_sva (
    input wire        core_clk,
    input wire        rst,
    input wire        ce,
    input wire        wr_wide,
    input wire        rd_wide,
    input wire [13:0] nearly_empty_threshold,
    input wire [13:0] nearly_full_threshold,
    input wire [13:0] full_threshold,
    input wire [2:0]  wr_cs,
    input wire [2:0]  wr_cs_invert,
    input wire [2:0]  rd_cs,
    input wire [2:0]  rd_cs_invert,
    input wire [17:0] rd_data,
    input wire        rd_valid,
    input wire        wr_done,
    input wire        empty_out,
    input wire        full_out,
    input wire        nearly_empty_out,
    input wire        nearly_full_out,
    input wire [10:0] level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Threshold units in halves; a wide port drops the lowest unit bit.
    wire        wd  = wr_wide | rd_wide;
    wire [9:0]  neu = {nearly_empty_threshold[12:4], nearly_empty_threshold[3] & ~wd};
    wire [9:0]  nfu = {nearly_full_threshold[12:4], nearly_full_threshold[3] & ~wd};
    wire [9:0]  fu  = {full_threshold[12:4], full_threshold[3] & ~wd};
    wire [10:0] cap = (fu == 10'h000) ? 11'h400 : {1'b0, fu};
    wire        acc = wr_done | rd_valid;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Pulses only count as fresh when the edge before had the clock enable high.
    a_reset_flags: assert property ($fell(rst) && $past(ce) |-> empty_out && nearly_empty_out
        && !full_out && !nearly_full_out && level == 11'h000) else $error("flags wrong after reset");
    a_empty_zero: assert property (empty_out == (level == 11'h000)) else $error("empty flag off");
    a_ne_level: assert property (acc && $past(ce) |-> nearly_empty_out == (level <= {1'b0, $past(neu)}))
        else $error("nearly empty flag off");
    a_nf_level: assert property (acc && $past(ce) |-> nearly_full_out ==
        ($past(nfu) != 10'h000 && level >= {1'b0, $past(nfu)})) else $error("nearly full flag off");
    a_full_level: assert property (acc && $past(ce) |-> full_out == (level >= $past(cap)))
        else $error("full flag off");
    a_write_sel: assert property (wr_done && $past(ce) |-> $past(&(wr_cs ^ wr_cs_invert)))
        else $error("write without select");
    a_read_sel: assert property (rd_valid && $past(ce) |-> $past(&(rd_cs ^ rd_cs_invert)))
        else $error("read without select");
    a_level_step: assert property (wr_done && !rd_valid && $past(ce) |->
        level == $past(level) + ($past(wr_wide) ? 11'h002 : 11'h001)) else $error("level step wrong");
    a_idle_hold: assert property (!acc && !$past(rst) |-> $stable(level)) else $error("level moved");
    a_narrow_high: assert property (rd_valid && $past(ce) && !$past(rd_wide) |->
        rd_data[17:9] == 9'h000) else $error("narrow read high half");
endmodule // fifo_flags_sva

bind embedded_fifo_flags fifo_flags_sva i_sva (.core_clk, .rst, .ce, .wr_wide, .rd_wide,
    .nearly_empty_threshold, .nearly_full_threshold, .full_threshold, .wr_cs, .wr_cs_invert,
    .rd_cs, .rd_cs_invert, .rd_data, .rd_valid, .wr_done, .empty_out, .full_out,
    .nearly_empty_out, .nearly_full_out, .level);

// [tb/embedded_fifo_flags_bench.sv]
// Random traffic against a queue model of the FIFO, checked every cycle.
module embedded_fifo_flags_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        wr_wide = 1'b0;
    logic        rd_wide = 1'b0;
    logic        big_endian = 1'b1;
    logic [13:0] ne_thr = 14'h0010;
    logic [13:0] nf_thr = 14'h0020;
    logic [13:0] f_thr = 14'h0040;
    logic [2:0]  wr_inv = 3'h0;
    logic [2:0]  rd_inv = 3'h0;
    logic [17:0] wr_data = 18'h00000;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        obey = 1'b1;
    wire  [2:0]  wr_cs, rd_cs;
    wire  [17:0] rd_data;
    wire  [10:0] level;
    wire         rd_valid, wr_done, e_out, ne_out, f_out, nf_out;
    wire  [34:0] got = {rd_data, rd_valid, wr_done, e_out, ne_out, f_out, nf_out, level};
    logic [34:0] e_all;
    logic [17:0] e_data;
    logic [3:0]  e_fl;
    logic        e_rv, e_wd;
    logic [8:0]  q[$];
    int          err_total = 0, cmp_count = 0, cycles = 0, t, seed = 32'h03904b55;

    embedded_fifo_flags i_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .wr_wide(wr_wide),
        .rd_wide(rd_wide), .big_endian(big_endian), .nearly_empty_threshold(ne_thr),
        .nearly_full_threshold(nf_thr), .full_threshold(f_thr), .wr_cs(wr_cs), .wr_cs_invert(wr_inv),
        .wr_data(wr_data), .rd_cs(rd_cs), .rd_cs_invert(rd_inv), .rd_data(rd_data), .rd_valid(rd_valid),
        .wr_done(wr_done), .empty_out(e_out), .nearly_empty_out(ne_out), .full_out(f_out),
        .nearly_full_out(nf_out), .level(level));
    fifo_user_model i_user (.wr_en(wr_en), .rd_en(rd_en), .obey(obey), .full_out(f_out), .empty_out(e_out),
        .wr_cs_invert(wr_inv), .rd_cs_invert(rd_inv), .wr_cs(wr_cs), .rd_cs(rd_cs));

    // The clock, and a cycle ceiling in case the run hangs.
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            finish_test();
        end
    end

    // Threshold units in halves; bit 13 and the low bits fall away.
    function automatic int units(logic [13:0] v);
        return (v >> 3) & ((wr_wide || rd_wide) ? 1022 : 1023);
    endfunction

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One clock: model takes the pre-edge inputs, then compares settled outputs.
    task automatic cycle();
        logic [8:0] a, b;
        logic       w, r;
        int         cap;
        @(posedge core_clk);
        cap = (units(f_thr) == 0) ? 1024 : units(f_thr);
        w = &(wr_cs ^ wr_inv) && q.size() + (wr_wide ? 2 : 1) <= cap;
        r = &(rd_cs ^ rd_inv) && q.size() >= (rd_wide ? 2 : 1);
        if (ce && rst) begin
            q = {};
            {e_data, e_rv, e_wd, e_fl} = {18'h00000, 6'h0c};
        end else if (ce) begin
            {e_rv, e_wd} = {r, w};
            if (r) begin
                a = q.pop_front();
                b = rd_wide ? q.pop_front() : 9'h000;
                e_data = !rd_wide ? {9'h000, a} : big_endian ? {b, a} : {a, b};
            end
            if (w)
                q.push_back(wr_wide && !big_endian ? wr_data[17:9] : wr_data[8:0]);
            if (w && wr_wide)
                q.push_back(big_endian ? wr_data[17:9] : wr_data[8:0]);
            e_fl = {q.size() == 0, q.size() <= units(ne_thr), q.size() >= cap,
                    units(nf_thr) != 0 && q.size() >= units(nf_thr)};
        end
        e_all = {e_data, e_rv, e_wd, e_fl, 11'(q.size())};
        #1;
        cmp_count++;
        if (got !== e_all) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, e_all);
        end
    endtask

    // Eight width and order mixes: fill to full, drain, then random traffic with resets.
    initial begin
        repeat (5) cycle();
        rst = 1'b0;
        for (int c = 0; c < 8; c++) begin
            {big_endian, rd_wide, wr_wide} = c[2:0];
            t = $random(seed);
            f_thr = 14'(((t & 31) + 4) << 4) | 14'((t >>> 20) & 14'h200f);
            ne_thr = 14'((((t >>> 5) & 3) + 1) << 4);
            nf_thr = f_thr - 14'h0020;
            {wr_inv, rd_inv} = t[29:24];
            for (int p = 0; p < 3; p++)
                repeat (90) begin
                    t = $random(seed);
                    wr_data = t[17:0];
                    wr_en = p == 0 || (p == 2 && t[20]);
                    rd_en = p == 1 || (p == 2 && t[21]);
                    obey = p != 2;
                    ce = p != 2 || t[24:22] != 3'h0;
                    rst = p == 2 && t[31:25] == 7'h00;
                    cycle();
                end
        end
        finish_test();
    end
endmodule // embedded_fifo_flags_bench
